// [fapl_pkg.sv]
// Overview of operation
// RULE1 - debug path may access unlocked pages
// RULE2 - debug path refused on locked pages
// RULE3 - each lock bit guards one 8k block
// RULE4 - debug reads of lock bytes always allowed
// RULE5 - debug writes clearing lock bits always allowed
// RULE6 - unlocked security page erase resets lock bytes
// RULE7 - locked security page needs full debug erase
// RULE8 - reserved area refused for every source
// RULE9 - reserved area is 0xfe00 to 0xffff
// RULE10 - firmware ignores the lock bytes
// RULE11 - lower firmware may access all but security-page erase
// RULE12 - firmware never erases the security page
// RULE13 - firmware may read and write security page
// RULE14 - upper firmware limited to pages at/above limit
// RULE15 - upper firmware blocked below the limit
// RULE16 - blocked firmware reads return 0x00
// RULE17 - limit address is limit register times 256
// RULE18 - upper code may execute below the limit
// RULE19 - firmware classified by instruction address versus limit
// RULE20 - firmware write/erase needs enable bit set
package fapl_pkg;

    // ------------------------------------------------------------
    // register map and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] FLASH_CTRL_ADDR = 8'hb7;
    localparam logic [7:0] STORE_CTRL_ADDR = 8'h8f;
    localparam logic [7:0] LIMIT_ADDR = 8'hb6;
    localparam logic [7:0] FLASH_CTRL_RESET = 8'h80;
    localparam logic [7:0] STORE_CTRL_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [7:0] FLASH_CTRL_MASK = 8'hc1;
    localparam logic [7:0] STORE_CTRL_MASK = 8'h07;
    localparam int ONESHOT_BIT = 7;
    localparam int READ_ALWAYS_BIT = 6;
    localparam int WRITE_ERASE_EN_BIT = 0;
    localparam int SCRATCH_SEL_BIT = 2;
    localparam int ERASE_EN_BIT = 1;
    localparam int WRITE_EN_BIT = 0;

    // ------------------------------------------------------------
    // flash layout
    // ------------------------------------------------------------
    localparam logic [15:0] RESERVED_BASE = 16'hfe00;
    localparam logic [15:0] WRITE_LOCK_ADDR = 16'hfdfe;
    localparam logic [15:0] READ_LOCK_ADDR = 16'hfdff;
    localparam logic [6:0] SECURITY_PAGE = 7'h7e;
    localparam int PAGE_LSB = 9;
    localparam int BLOCK_LSB = 13;
    localparam logic [7:0] LOCK_ERASED = 8'hff;
    localparam logic [7:0] BLOCKED_DATA = 8'h00;

    typedef enum logic [1:0] {
        SRC_DEBUG,
        SRC_FIRMWARE
    } fapl_src_e;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_ERASE,
        OP_FETCH
    } fapl_op_e;

endpackage

// [fapl_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fapl_top (
    input wire logic clk,
    input wire logic rst_n,
    // special function register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrRead,
    output logic [7:0] sfrRdata,
    // stored lock bytes, sampled once after reset
    input wire logic [7:0] storedReadLock,
    input wire logic [7:0] storedWriteLock,
    // access request
    input wire logic reqValid,
    input wire fapl_pkg::fapl_src_e reqSrc,
    input wire fapl_pkg::fapl_op_e reqOp,
    input wire logic [15:0] reqAddr,
    input wire logic [15:0] reqPc,
    input wire logic [7:0] reqWdata,
    input wire logic [7:0] flashRdata,
    // verdict
    output logic respValid,
    output logic respAllow,
    output logic [7:0] respData,
    output logic respEraseAll,
    output logic [7:0] readLockOut,
    output logic [7:0] writeLockOut,
    output logic oneshotEnable,
    output logic readAlwaysEnable,
    output logic scratchpadSelect
);
    import fapl_pkg::*;

    logic [7:0] flashCtrl_reg;
    logic [7:0] storeCtrl_reg;
    logic [7:0] limit_reg;
    logic [7:0] readLock_reg;
    logic [7:0] writeLock_reg;
    logic locksLoaded_reg;
    logic [15:0] limitAddr;
    logic inReserved, onSecPage, onLockByte, isUpper, belowLimit;
    logic [2:0] blockIdx;
    logic allowNext, eraseAllNext, resetLocksNext;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // reserved bits are held at zero so they read back as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flashCtrl_reg <= FLASH_CTRL_RESET; // RULE20
            storeCtrl_reg <= STORE_CTRL_RESET;
            limit_reg <= LIMIT_RESET;
        end else if (sfrWrite) begin
            if (sfrAddr == FLASH_CTRL_ADDR) flashCtrl_reg <= sfrWdata & FLASH_CTRL_MASK;
            if (sfrAddr == STORE_CTRL_ADDR) storeCtrl_reg <= sfrWdata & STORE_CTRL_MASK;
            if (sfrAddr == LIMIT_ADDR) limit_reg <= sfrWdata;
        end
    end

    // read data; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sfrRdata <= 8'h00;
        end else if (sfrRead) begin
            case (sfrAddr)
                FLASH_CTRL_ADDR: sfrRdata <= flashCtrl_reg;
                STORE_CTRL_ADDR: sfrRdata <= storeCtrl_reg;
                LIMIT_ADDR: sfrRdata <= limit_reg;
                default: sfrRdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // address classification
    // ------------------------------------------------------------
    assign limitAddr = {limit_reg, 8'h00}; // RULE17
    assign inReserved = (reqAddr >= RESERVED_BASE); // RULE8 RULE9
    assign onSecPage = (reqAddr[15:PAGE_LSB] == SECURITY_PAGE);
    assign onLockByte = (reqAddr == WRITE_LOCK_ADDR) || (reqAddr == READ_LOCK_ADDR);
    assign blockIdx = reqAddr[15:BLOCK_LSB]; // RULE3
    assign isUpper = (reqPc >= limitAddr); // RULE19
    assign belowLimit = (reqAddr < limitAddr);

    // ------------------------------------------------------------
    // permission decision
    // ------------------------------------------------------------
    // one combinational verdict, registered below so outputs are flops
    always_comb begin
        allowNext = 1'b0;
        eraseAllNext = 1'b0;
        resetLocksNext = 1'b0;
        if (inReserved) begin
            allowNext = 1'b0; // RULE8
        end else if (reqSrc == SRC_DEBUG) begin
            case (reqOp)
                OP_READ: allowNext = onLockByte || readLock_reg[blockIdx]; // RULE4 RULE1 RULE2
                OP_WRITE: allowNext = onLockByte || writeLock_reg[blockIdx]; // RULE5 RULE2
                OP_ERASE: begin
                    if (onLockByte) begin
                        // addressing a lock byte starts a whole-device erase
                        allowNext = 1'b1; // RULE7
                        eraseAllNext = 1'b1;
                        resetLocksNext = 1'b1;
                    end else if (onSecPage) begin
                        allowNext = writeLock_reg[blockIdx]; // RULE6 RULE7
                        resetLocksNext = writeLock_reg[blockIdx]; // RULE6
                    end else begin
                        allowNext = writeLock_reg[blockIdx]; // RULE1 RULE2
                    end
                end
                OP_FETCH: allowNext = 1'b1;
                default: allowNext = 1'b0;
            endcase
        end else begin
            // lock bytes play no part on this path
            case (reqOp) // RULE10
                OP_FETCH: allowNext = 1'b1; // RULE18
                OP_READ: allowNext = !(isUpper && belowLimit); // RULE11 RULE13 RULE14 RULE15
                OP_WRITE: allowNext = !(isUpper && belowLimit)
                    && flashCtrl_reg[WRITE_ERASE_EN_BIT] && storeCtrl_reg[WRITE_EN_BIT]; // RULE20 RULE13
                OP_ERASE: allowNext = !(isUpper && belowLimit) && !onSecPage // RULE12 RULE15
                    && flashCtrl_reg[WRITE_ERASE_EN_BIT] && storeCtrl_reg[WRITE_EN_BIT]
                    && storeCtrl_reg[ERASE_EN_BIT]; // RULE20
                default: allowNext = 1'b0;
            endcase
        end
    end

    // verdict register; refused reads hand back zero, never the contents
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            respValid <= 1'b0;
            respAllow <= 1'b0;
            respData <= BLOCKED_DATA;
            respEraseAll <= 1'b0;
        end else begin
            respValid <= reqValid;
            respAllow <= reqValid && allowNext;
            respEraseAll <= reqValid && eraseAllNext;
            respData <= (reqValid && allowNext && reqOp == OP_READ) ? flashRdata
                : BLOCKED_DATA; // RULE16
        end
    end

    // ------------------------------------------------------------
    // lock byte shadow
    // ------------------------------------------------------------
    // flash writes only clear bits, so a write is an and; the stored
    // bytes are caught on the first clock after reset release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            locksLoaded_reg <= 1'b0;
            readLock_reg <= LOCK_ERASED;
            writeLock_reg <= LOCK_ERASED;
        end else if (!locksLoaded_reg) begin
            locksLoaded_reg <= 1'b1;
            readLock_reg <= storedReadLock;
            writeLock_reg <= storedWriteLock;
        end else if (reqValid && resetLocksNext && reqSrc == SRC_DEBUG && reqOp == OP_ERASE) begin
            readLock_reg <= LOCK_ERASED; // RULE6
            writeLock_reg <= LOCK_ERASED;
        end else if (reqValid && allowNext && reqOp == OP_WRITE) begin
            if (reqAddr == READ_LOCK_ADDR) readLock_reg <= readLock_reg & reqWdata; // RULE5 RULE13
            if (reqAddr == WRITE_LOCK_ADDR) writeLock_reg <= writeLock_reg & reqWdata;
        end
    end

    // lock byte copies and flag outputs, one flop stage from the lock shadow and control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readLockOut <= LOCK_ERASED;
            writeLockOut <= LOCK_ERASED;
            oneshotEnable <= FLASH_CTRL_RESET[ONESHOT_BIT];
            readAlwaysEnable <= FLASH_CTRL_RESET[READ_ALWAYS_BIT];
            scratchpadSelect <= STORE_CTRL_RESET[SCRATCH_SEL_BIT];
        end else begin
            readLockOut <= readLock_reg;
            writeLockOut <= writeLock_reg;
            oneshotEnable <= flashCtrl_reg[ONESHOT_BIT];
            readAlwaysEnable <= flashCtrl_reg[READ_ALWAYS_BIT];
            scratchpadSelect <= storeCtrl_reg[SCRATCH_SEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_fw_upper_low;
        reqValid && reqSrc == SRC_FIRMWARE && reqOp != OP_FETCH
            && reqPc >= {limit_reg, 8'h00} && reqAddr < {limit_reg, 8'h00};
    endsequence

    sequence s_dbg_lock_erase;
        reqValid && reqSrc == SRC_DEBUG && reqOp == OP_ERASE
            && (reqAddr == 16'hfdfe || reqAddr == 16'hfdff);
    endsequence

    a_reserved_refused: assert property (reqValid && reqAddr >= 16'hfe00 |=> respValid && !respAllow) // RULE8
        else $error("reserved area access allowed");
    a_upper_low_block: assert property (s_fw_upper_low |=> !respAllow && respData == 8'h00) // RULE15
        else $error("upper firmware reached below limit");
    a_refused_zero: assert property (respValid && !respAllow |-> respData == 8'h00) // RULE16
        else $error("refused read returned data");
    a_fw_sec_erase: assert property (reqValid && reqSrc == SRC_FIRMWARE && reqOp == OP_ERASE
        && reqAddr[15:9] == 7'h7e |=> !respAllow) // RULE12
        else $error("firmware erased security page");
    a_wren_gate: assert property (reqValid && reqSrc == SRC_FIRMWARE && reqOp == OP_WRITE
        && !flashCtrl_reg[0] |=> !respAllow) // RULE20
        else $error("firmware write without enable");
    a_lock_read_ok: assert property (reqValid && reqSrc == SRC_DEBUG && reqOp == OP_READ
        && (reqAddr == 16'hfdfe || reqAddr == 16'hfdff) |=> respAllow) // RULE4
        else $error("lock byte read refused");
    a_dbg_locked: assert property (reqValid && reqSrc == SRC_DEBUG && reqOp == OP_READ
        && reqAddr < 16'hfdfe && !readLock_reg[reqAddr[15:13]] |=> !respAllow) // RULE2
        else $error("locked block read allowed");
    a_full_erase: assert property (s_dbg_lock_erase |=> respAllow && respEraseAll
        && readLock_reg == 8'hff && writeLock_reg == 8'hff ##1 writeLockOut == 8'hff) // RULE7
        else $error("full erase did not clear locks");
    a_lock_clear: assert property (locksLoaded_reg && reqValid && reqOp == OP_WRITE
        && reqAddr == 16'hfdfe |=> writeLock_reg == ($past(writeLock_reg) & $past(reqWdata))
        || !respAllow) // RULE5
        else $error("lock write not anded in");
    a_limit_exec: assert property (reqValid && reqSrc == SRC_FIRMWARE && reqOp == OP_FETCH
        && reqAddr < 16'hfe00 |=> respAllow) // RULE18
        else $error("fetch below limit refused");

endmodule
`default_nettype wire

// [fapl_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// flash array and stored lock bytes as seen from the permission logic
module fapl_flash_model #(
    parameter logic [7:0] READ_LOCK = 8'hff,
    parameter logic [7:0] WRITE_LOCK = 8'hff
) (
    input wire logic [15:0] reqAddr,
    output logic [7:0] flashRdata,
    output logic [7:0] storedReadLock,
    output logic [7:0] storedWriteLock
);
    // contents follow the address so a byte from the wrong place shows up
    assign flashRdata = reqAddr[15:8] ^ reqAddr[7:0] ^ 8'h5a;
    assign storedReadLock = READ_LOCK;
    assign storedWriteLock = WRITE_LOCK;
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fapl_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0, reqValid = 1'b0;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, reqWdata = 8'h00;
    logic [15:0] reqAddr = 16'h0000, reqPc = 16'h0000;
    fapl_src_e reqSrc = SRC_DEBUG;
    fapl_op_e reqOp = OP_READ;
    logic [7:0] sfrRdata, respData, readLockOut, writeLockOut, flashRdata, rdLk, wrLk;
    logic respValid, respAllow, respEraseAll, oneshotEnable, readAlwaysEnable, scratchpadSelect;
    int fail_count = 0, compares = 0, cycles = 0;
    // ----------------------------------------
    // clock, partner and design
    // ----------------------------------------
    always #20 clk = ~clk;
    // block 0 and 7 read locked, block 1 write locked, security page writable
    fapl_flash_model #(.READ_LOCK(8'h7e), .WRITE_LOCK(8'hfd)) flash (.reqAddr(reqAddr),
        .flashRdata(flashRdata), .storedReadLock(rdLk), .storedWriteLock(wrLk));
    fapl_top DUT (.clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrWdata(sfrWdata), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
        .storedReadLock(rdLk), .storedWriteLock(wrLk), .reqValid(reqValid), .reqSrc(reqSrc),
        .reqOp(reqOp), .reqAddr(reqAddr), .reqPc(reqPc), .reqWdata(reqWdata),
        .flashRdata(flashRdata), .respValid(respValid), .respAllow(respAllow),
        .respData(respData), .respEraseAll(respEraseAll), .readLockOut(readLockOut),
        .writeLockOut(writeLockOut), .oneshotEnable(oneshotEnable),
        .readAlwaysEnable(readAlwaysEnable), .scratchpadSelect(scratchpadSelect));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // a stuck design never answers, so the run is cut after a generous margin
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 2000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = 1'b1;
        @(posedge clk);
        #1 sfrWrite = 1'b0;
        // one idle edge, so a following call never lowers and raises the strobe at once
        @(posedge clk);
        #1;
    endtask
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        sfrAddr = a;
        sfrRead = 1'b1;
        @(posedge clk);
        #1 sfrRead = 1'b0;
        check("sfrRdata", sfrRdata, exp);
        @(posedge clk);
        #1;
    endtask
    // one request, then the verdict that stands for the following cycle
    task automatic req(input fapl_src_e s, input fapl_op_e o, input logic [15:0] a,
        input logic [15:0] pc, input logic allow, input logic [7:0] wd = 8'h00);
        logic [7:0] expData;
        logic expAll;
        expData = (allow && o == OP_READ) ? (a[15:8] ^ a[7:0] ^ 8'h5a) : 8'h00;
        expAll = allow && s == SRC_DEBUG && o == OP_ERASE && a[15:1] == 15'h7eff;
        reqSrc = s;
        reqOp = o;
        reqAddr = a;
        reqPc = pc;
        reqWdata = wd;
        reqValid = 1'b1;
        @(posedge clk);
        #1 reqValid = 1'b0;
        check("respValid", {7'h00, respValid}, 8'h01);
        check("respAllow", {7'h00, respAllow}, {7'h00, allow});
        check("respData", respData, expData);
        check("respEraseAll", {7'h00, respEraseAll}, {7'h00, expAll});
        // idle edge between requests keeps the strobe a clean pulse
        @(posedge clk);
        #1;
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 sfr_rd(8'hb7, 8'h80);
        sfr_rd(8'h8f, 8'h00);
        sfr_rd(8'hb6, 8'h00);
        sfr_rd(8'h33, 8'h00);
        check("oneshotEnable", {7'h00, oneshotEnable}, 8'h01);
        check("readAlwaysEnable", {7'h00, readAlwaysEnable}, 8'h00);
        check("scratchpadSelect", {7'h00, scratchpadSelect}, 8'h00);
        sfr_wr(8'hb7, 8'hff);
        sfr_rd(8'hb7, 8'hc1);
        check("oneshotEnable", {7'h00, oneshotEnable}, 8'h01);
        check("readAlwaysEnable", {7'h00, readAlwaysEnable}, 8'h01);
        req(SRC_DEBUG, OP_READ, 16'h0100, 16'h0000, 1'b0);
        req(SRC_DEBUG, OP_READ, 16'h2100, 16'h0000, 1'b1);
        req(SRC_DEBUG, OP_WRITE, 16'h2100, 16'h0000, 1'b0);
        req(SRC_DEBUG, OP_WRITE, 16'h4000, 16'h0000, 1'b1);
        req(SRC_DEBUG, OP_READ, 16'hfdff, 16'h0000, 1'b1);
        req(SRC_DEBUG, OP_READ, 16'hfc00, 16'h0000, 1'b0);
        req(SRC_DEBUG, OP_READ, 16'hfe00, 16'h0000, 1'b0);
        req(SRC_DEBUG, OP_FETCH, 16'h0100, 16'h0000, 1'b1);
        sfr_wr(8'h8f, 8'hff);
        sfr_rd(8'h8f, 8'h07);
        check("scratchpadSelect", {7'h00, scratchpadSelect}, 8'h01);
        sfr_wr(8'h8f, 8'h03);
        sfr_wr(8'hb7, 8'h00);
        req(SRC_FIRMWARE, OP_WRITE, 16'h4000, 16'h0100, 1'b0);
        sfr_wr(8'hb7, 8'h01);
        req(SRC_FIRMWARE, OP_WRITE, 16'h4000, 16'h0100, 1'b1);
        req(SRC_FIRMWARE, OP_READ, 16'h0100, 16'h0100, 1'b1);
        req(SRC_FIRMWARE, OP_ERASE, 16'hfc00, 16'h0100, 1'b0);
        req(SRC_FIRMWARE, OP_ERASE, 16'h4000, 16'h0100, 1'b1);
        req(SRC_FIRMWARE, OP_WRITE, 16'hfdfe, 16'h0100, 1'b1, 8'hbf);
        req(SRC_FIRMWARE, OP_READ, 16'hffff, 16'h0100, 1'b0);
        repeat (3) @(posedge clk);
        #1 check("writeLockOut", writeLockOut, 8'hbd);
        req(SRC_DEBUG, OP_WRITE, 16'hc000, 16'h0000, 1'b0);
        sfr_wr(8'hb6, 8'h80);
        sfr_rd(8'hb6, 8'h80);
        req(SRC_FIRMWARE, OP_READ, 16'h1000, 16'h9000, 1'b0);
        req(SRC_FIRMWARE, OP_READ, 16'h1000, 16'h7f00, 1'b1);
        req(SRC_FIRMWARE, OP_READ, 16'h8000, 16'h9000, 1'b1);
        req(SRC_FIRMWARE, OP_WRITE, 16'h7fff, 16'h8000, 1'b0);
        req(SRC_FIRMWARE, OP_FETCH, 16'h1000, 16'h9000, 1'b1);
        req(SRC_FIRMWARE, OP_ERASE, 16'hfc00, 16'h9000, 1'b0);
        req(SRC_DEBUG, OP_ERASE, 16'hfc00, 16'h0000, 1'b1);
        repeat (3) @(posedge clk);
        #1 check("readLockOut", readLockOut, 8'hff);
        check("writeLockOut", writeLockOut, 8'hff);
        req(SRC_DEBUG, OP_WRITE, 16'hfdfe, 16'h0000, 1'b1, 8'h7f);
        req(SRC_DEBUG, OP_ERASE, 16'hfc00, 16'h0000, 1'b0);
        req(SRC_DEBUG, OP_ERASE, 16'hfdff, 16'h0000, 1'b1);
        repeat (3) @(posedge clk);
        #1 check("writeLockOut", writeLockOut, 8'hff);
        conclude();
    end
endmodule
`default_nettype wire
